// File: core/spab_partner_ability.sv
// partner ability capture, page flag and digital control for the serial pcs
`timescale 1ns/1ps
// Operation
// - on negotiation completion, hold partner's last base-page codeword for software reads
// - ability bit 15 mirrors partner next-page; local next page never sent
// - ability bit 14 shows partner acknowledge bit
// - bits 13:12 show partner fault: none, offline, link failure, negotiation error
// - bits 8:7 show partner pause ability with the standard encoding
// - bit 6 reads one when partner advertises half duplex
// - bit 5 reads one when partner advertises full duplex; resets zero
// - expansion bit 1 latches high when a partner codeword arrives
// - control bit 14 loops received serial data back onto transmit
// - control bit 11 powers down receiver and transmitter, keeps pll
// - completion bit sets after acknowledge codewords exchanged
// - mode field selects serdes 00 or sgmii 10, reset to 10
// - serdes mode transmit codeword built from local advertisement fields
module spab_partner_ability
    import spab_pkg::*;
#(
    parameter int DATA_W = 10
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // management register port
    input  wire logic [23:0]       regAddr,
    input  wire logic              regRead,
    input  wire logic              regWrite,
    input  wire logic [15:0]       regWrData,
    output logic      [15:0]       regRdData,
    // negotiation side of the pcs
    input  wire logic              rxPageStrobe,
    input  wire logic [15:0]       rxCodeword,
    input  wire logic              txAckSent,
    input  wire logic              anRestart,
    input  wire logic [15:0]       localAdvert,
    input  wire logic              localAck,
    output logic      [15:0]       txCodeword,
    output logic                   txCodewordValid,
    output logic                   anComplete,
    output logic      [1:0]        pcsMode,
    // serial data path
    input  wire logic [DATA_W-1:0] rxData,
    input  wire logic [DATA_W-1:0] txDataIn,
    output logic      [DATA_W-1:0] txData,
    output logic                   rxEnable,
    output logic                   txEnable,
    output logic                   pllEnable
);
    // refuse a data path width the serial mux cannot carry
    if (DATA_W < 1) begin : g_bad_width
        $error("DATA_W must be at least one");
    end

    logic [15:0]       ability_reg, ability_next;
    logic [15:0]       lastCw_reg, lastCw_next;
    logic              anDone_reg, anDone_next;
    logic [15:0]       digCtrl_reg, digCtrl_next;
    logic [1:0]        mode_reg, mode_next;
    logic [15:0]       rdData_reg, rdData_next;
    logic [15:0]       txCw_reg, txCw_next;
    logic [DATA_W-1:0] txData_reg, txData_next;
    logic              pageRx;
    logic              expRead;
    logic              loopOn;
    logic              pwrSave;
    logic              ackSeen;

    assign expRead = regRead && (regAddr == SPAB_ADDR_EXPANSION);
    assign loopOn  = digCtrl_reg[SPAB_BIT_LOOPBACK];
    assign pwrSave = digCtrl_reg[SPAB_BIT_PWRSAVE];
    assign ackSeen = rxPageStrobe && rxCodeword[SPAB_BIT_ACK] && txAckSent;

    // page received flag, cleared by reading the expansion register
    spab_sticky_flag u_page_flag (
        .clk      (clk),
        .reset    (reset),
        .setEvent (rxPageStrobe),
        .clearReq (expRead),
        .flag     (pageRx)
    );

    // negotiation state: last codeword, completion and captured ability
    always_comb begin
        lastCw_next  = lastCw_reg;
        anDone_next  = anDone_reg;
        ability_next = ability_reg;
        if (rxPageStrobe) begin
            lastCw_next = rxCodeword;
        end
        if (anRestart) begin
            anDone_next = 1'h0;
        end else if (ackSeen) begin
            anDone_next = 1'h1;
        end
        // capture only on completion so software sees a stable page
        if (ackSeen && !anRestart && !anDone_reg) begin
            ability_next = rxCodeword & SPAB_ABILITY_MASK;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lastCw_reg  <= SPAB_ZERO16;
            anDone_reg  <= 1'h0;
            ability_reg <= SPAB_ZERO16;
        end else begin
            lastCw_reg  <= lastCw_next;
            anDone_reg  <= anDone_next;
            ability_reg <= ability_next;
        end
    end

    // control registers; reserved mode codes are ignored on write
    always_comb begin
        digCtrl_next = digCtrl_reg;
        mode_next    = mode_reg;
        if (regWrite && regAddr == SPAB_ADDR_DIGCTRL) begin
            digCtrl_next = regWrData;
        end
        if (regWrite && regAddr == SPAB_ADDR_ANCTRL) begin
            if (regWrData[SPAB_MODE_HI:SPAB_MODE_LO] == SPAB_MODE_SERDES ||
                regWrData[SPAB_MODE_HI:SPAB_MODE_LO] == SPAB_MODE_SGMII) begin
                mode_next = regWrData[SPAB_MODE_HI:SPAB_MODE_LO];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            digCtrl_reg <= SPAB_DIGCTRL_RESET;
            mode_reg    <= SPAB_MODE_RESET;
        end else begin
            digCtrl_reg <= digCtrl_next;
            mode_reg    <= mode_next;
        end
    end

    // read mux, one cycle latency; unmapped addresses read zero
    always_comb begin
        rdData_next = rdData_reg;
        if (regRead) begin
            rdData_next = SPAB_ZERO16;
            if (regAddr == SPAB_ADDR_ABILITY) begin
                rdData_next = ability_reg;
            end else if (regAddr == SPAB_ADDR_EXPANSION) begin
                rdData_next[SPAB_BIT_PAGERX] = pageRx;
            end else if (regAddr == SPAB_ADDR_DIGCTRL) begin
                rdData_next = digCtrl_reg;
            end else if (regAddr == SPAB_ADDR_ANCTRL) begin
                rdData_next[SPAB_MODE_HI:SPAB_MODE_LO] = mode_reg;
                rdData_next[SPAB_BIT_ANDONE] = anDone_reg;
            end
        end
    end

    // transmit codeword and serial data path
    always_comb begin
        txCw_next = SPAB_ZERO16;
        if (mode_reg == SPAB_MODE_SERDES) begin
            txCw_next = localAdvert & SPAB_ABILITY_MASK;
            txCw_next[SPAB_BIT_ACK] = localAck;
        end
        txCw_next[SPAB_BIT_NEXTPAGE] = 1'h0;
        // powered-down transmitter sends nothing, loopback included
        if (pwrSave) begin
            txData_next = '0;
        end else if (loopOn) begin
            txData_next = rxData;
        end else begin
            txData_next = txDataIn;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdData_reg <= SPAB_ZERO16;
            txCw_reg   <= SPAB_ZERO16;
            txData_reg <= '0;
        end else begin
            rdData_reg <= rdData_next;
            txCw_reg   <= txCw_next;
            txData_reg <= txData_next;
        end
    end

    assign regRdData       = rdData_reg;
    assign txCodeword      = txCw_reg;
    assign txCodewordValid = (mode_reg == SPAB_MODE_SERDES);
    assign anComplete      = anDone_reg;
    assign pcsMode         = mode_reg;
    assign txData          = txData_reg;
    assign rxEnable        = !pwrSave;
    assign txEnable        = !pwrSave;
    assign pllEnable       = 1'h1;     // pll stays up in power save

    a_ability_capture: assert property (@(posedge clk) disable iff (reset)
        $rose(anDone_reg) |-> ability_reg == ($past(rxCodeword) & SPAB_ABILITY_MASK))
        else $error("ability not captured at completion");
    a_ability_hold: assert property (@(posedge clk) disable iff (reset)
        anDone_reg && $past(anDone_reg) |-> $stable(ability_reg))
        else $error("ability changed after completion");
    a_no_nextpage: assert property (@(posedge clk) disable iff (reset)
        txCodeword[SPAB_BIT_NEXTPAGE] == 1'h0)
        else $error("next page advertised");
    a_ability_read: assert property (@(posedge clk) disable iff (reset)
        regRead && regAddr == SPAB_ADDR_ABILITY |=> regRdData == $past(ability_reg))
        else $error("ability read wrong");
    a_fault_pause: assert property (@(posedge clk) disable iff (reset)
        $rose(anDone_reg) |-> ability_reg[SPAB_FAULT_HI:SPAB_PAUSE_LO] ==
            ($past(rxCodeword[SPAB_FAULT_HI:SPAB_PAUSE_LO]) & 7'h63))
        else $error("fault or pause field wrong");
    a_duplex_bits: assert property (@(posedge clk) disable iff (reset)
        $rose(anDone_reg) |-> ability_reg[SPAB_BIT_HALFDUP:SPAB_BIT_FULLDUP] ==
            $past(rxCodeword[SPAB_BIT_HALFDUP:SPAB_BIT_FULLDUP]))
        else $error("duplex bits wrong");
    a_page_latch: assert property (@(posedge clk) disable iff (reset)
        rxPageStrobe |=> pageRx ##1 (pageRx || $past(expRead)))
        else $error("page flag not latched");
    a_read_clear: assert property (@(posedge clk) disable iff (reset)
        expRead && !rxPageStrobe |=> !pageRx)
        else $error("page flag not cleared by read");
    a_loopback_path: assert property (@(posedge clk) disable iff (reset)
        loopOn && !pwrSave |=> txData == $past(rxData))
        else $error("loopback data wrong");
    a_power_save: assert property (@(posedge clk) disable iff (reset)
        pwrSave |-> !rxEnable && !txEnable && pllEnable)
        else $error("power save enables wrong");
    a_an_complete: assert property (@(posedge clk) disable iff (reset)
        ackSeen && !anRestart |=> anComplete)
        else $error("completion not set");
    a_mode_legal: assert property (@(posedge clk) disable iff (reset)
        pcsMode == SPAB_MODE_SERDES || pcsMode == SPAB_MODE_SGMII)
        else $error("reserved mode code");
    a_tx_codeword: assert property (@(posedge clk) disable iff (reset)
        mode_reg == SPAB_MODE_SERDES && $stable(mode_reg) |=>
            txCodeword[SPAB_FAULT_HI:SPAB_BIT_FULLDUP] ==
            ($past(localAdvert[SPAB_FAULT_HI:SPAB_BIT_FULLDUP]) & 9'h18f))
        else $error("tx codeword not from advertisement");
endmodule // spab_partner_ability

// File: core/spab_pkg.sv
// constants for the serial pcs partner ability and digital control registers
package spab_pkg;
    // register addresses
    localparam logic [23:0] SPAB_ADDR_ABILITY = 24'h1f0005;
    localparam logic [23:0] SPAB_ADDR_EXPANSION = 24'h1f0006;
    localparam logic [23:0] SPAB_ADDR_DIGCTRL = 24'h1f8000;
    localparam logic [23:0] SPAB_ADDR_ANCTRL = 24'h1f8001;
    // partner ability / codeword field positions
    localparam int SPAB_BIT_NEXTPAGE = 15;
    localparam int SPAB_BIT_ACK = 14;
    localparam int SPAB_FAULT_HI = 13;
    localparam int SPAB_FAULT_LO = 12;
    localparam int SPAB_PAUSE_HI = 8;
    localparam int SPAB_PAUSE_LO = 7;
    localparam int SPAB_BIT_HALFDUP = 6;
    localparam int SPAB_BIT_FULLDUP = 5;
    // mask of codeword bits kept in the ability register (reserved read zero)
    localparam logic [15:0] SPAB_ABILITY_MASK = 16'hf1e0;
    // expansion register
    localparam int SPAB_BIT_PAGERX = 1;
    // digital control register
    localparam int SPAB_BIT_LOOPBACK = 14;
    localparam int SPAB_BIT_PWRSAVE = 11;
    localparam logic [15:0] SPAB_DIGCTRL_RESET = 16'h2400;
    // negotiation control register: mode field and status bit
    localparam int SPAB_MODE_HI = 2;
    localparam int SPAB_MODE_LO = 1;
    localparam int SPAB_BIT_ANDONE = 5;
    localparam logic [1:0] SPAB_MODE_SERDES = 2'h0;
    localparam logic [1:0] SPAB_MODE_SGMII = 2'h2;
    localparam logic [1:0] SPAB_MODE_RESET = 2'h2;
    localparam logic [15:0] SPAB_ZERO16 = 16'h0000;
endpackage

// File: core/spab_sticky_flag.sv
// sticky event flag, set by hardware, cleared by a host read
`timescale 1ns/1ps
module spab_sticky_flag (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // event and clear
    input  wire logic setEvent,
    input  wire logic clearReq,
    // state
    output logic      flag
);
    logic flag_reg;
    logic flag_next;

    // set wins over a clear in the same cycle so no page is lost
    always_comb begin
        flag_next = flag_reg;
        if (clearReq) begin
            flag_next = 1'h0;
        end
        if (setEvent) begin
            flag_next = 1'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_reg <= 1'h0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;
endmodule // spab_sticky_flag

// File: verif/spab_link_partner.sv
// link partner model: sends base pages and a running serial symbol stream
`timescale 1ns/1ps
module spab_link_partner (
    // clock
    input  wire logic        clk,
    // page request from the bench
    input  wire logic        pageGo,
    input  wire logic [15:0] pageWord,
    // partner outputs
    output logic             pageStrobe,
    output logic      [15:0] pageCode,
    output logic      [9:0]  symbols
);
    // one-cycle strobe; a released codeword is inverted, never left stale
    always @(posedge clk) begin
        pageStrobe <= pageGo;
        pageCode   <= pageGo ? pageWord : ~pageCode;
        symbols    <= symbols * 10'h3 + 10'h1;
    end
    initial begin
        pageStrobe = 1'h0;
        pageCode   = 16'h0000;
        symbols    = 10'h000;
    end
endmodule // spab_link_partner

// File: verif/tb.sv
// self-checking bench for partner ability capture and digital control
`timescale 1ns/1ps
module tb;
    import spab_pkg::*;
    logic        clk = 0, reset = 1, regRead = 0, regWrite = 0, pageGo = 0;
    logic        txAckSent = 0, anRestart = 0, localAck = 0, rxPageStrobe;
    logic        txCodewordValid, anComplete, rxEnable, txEnable, pllEnable;
    logic [23:0] regAddr = 0;
    logic [15:0] regWrData = 0, regRdData, pageWord = 0, rxCodeword;
    logic [15:0] localAdvert = 0, txCodeword, w, ability, c;
    logic [1:0]  pcsMode;
    logic [9:0]  rxData, txDataIn = 0, txData, pr, pi;
    logic [15:0] ctrls [4] = '{16'h0000, 16'h4000, 16'h0800, 16'h4800};
    int          miscompares = 0, check_count = 0, cycles = 0, seed, i, anDone;

    spab_partner_ability #(.DATA_W(10)) u_dut (.clk(clk), .reset(reset),
        .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
        .regWrData(regWrData), .regRdData(regRdData), .rxPageStrobe(rxPageStrobe),
        .rxCodeword(rxCodeword), .txAckSent(txAckSent), .anRestart(anRestart),
        .localAdvert(localAdvert), .localAck(localAck), .txCodeword(txCodeword),
        .txCodewordValid(txCodewordValid), .anComplete(anComplete), .pcsMode(pcsMode),
        .rxData(rxData), .txDataIn(txDataIn), .txData(txData), .rxEnable(rxEnable),
        .txEnable(txEnable), .pllEnable(pllEnable));
    spab_link_partner u_partner (.clk(clk), .pageGo(pageGo), .pageWord(pageWord),
        .pageStrobe(rxPageStrobe), .pageCode(rxCodeword), .symbols(rxData));

    always #2 clk = ~clk;

    // hang guard, far above the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd(input logic [23:0] a, input logic [15:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1;
        @(posedge clk);
        regRead <= 0;
        #1 chk("regRdData", regRdData, exp);
    endtask

    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1;
        @(posedge clk);
        regWrite <= 0;
    endtask

    // partner sends one page; model mirrors capture and completion
    task automatic page(input logic [15:0] pw);
        @(posedge clk);
        pageGo   <= 1;
        pageWord <= pw;
        @(posedge clk);
        pageGo <= 0;
        @(posedge clk);
        if (anDone == 0 && pw[14] && txAckSent) begin
            ability = pw & SPAB_ABILITY_MASK;
            anDone  = 1;
        end
        #1 chk("anComplete", {15'h0, anComplete}, anDone[15:0]);
    endtask

    task close_out;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        seed = 85627;
        anDone = 0;
        ability = 0;
        repeat (4) @(posedge clk);
        reset <= 0;
        rd(SPAB_ADDR_DIGCTRL, SPAB_DIGCTRL_RESET);
        rd(SPAB_ADDR_ANCTRL, 16'h0004);
        rd(24'h1f0007, 16'h0000);
        wr(SPAB_ADDR_ABILITY, 16'hffff);
        rd(SPAB_ADDR_ABILITY, 16'h0000);
        // ack seen but this end not yet acking: flag only, no capture
        page(16'h4020);
        rd(SPAB_ADDR_EXPANSION, 16'h0002);
        rd(SPAB_ADDR_EXPANSION, 16'h0000);
        rd(SPAB_ADDR_ABILITY, 16'h0000);
        @(posedge clk);
        txAckSent <= 1;
        // every fault and pause code, next page both ways
        for (i = 0; i < 4; i++) begin
            w = 16'($random(seed));
            w[14] = 1'h1;
            w[13:12] = i[1:0];
            w[8:7] = i[1:0];
            w[15] = i[0];
            page(w);
            page(~w | 16'h4000);
            rd(SPAB_ADDR_ABILITY, ability);
            rd(SPAB_ADDR_ANCTRL, 16'h0024);
            rd(SPAB_ADDR_EXPANSION, 16'h0002);
            @(posedge clk);
            anRestart <= 1;
            @(posedge clk);
            anRestart <= 0;
            anDone = 0;
            #1 chk("anComplete", {15'h0, anComplete}, 16'h0000);
        end
        // serdes codeword built from the local advertisement
        @(posedge clk);
        localAdvert <= 16'($random(seed));
        localAck    <= 1;
        // both reserved mode codes must leave the mode alone
        wr(SPAB_ADDR_ANCTRL, 16'h0002);
        wr(SPAB_ADDR_ANCTRL, 16'h0006);
        rd(SPAB_ADDR_ANCTRL, 16'h0004);
        chk("txCodeword", txCodeword, 16'h0000);
        chk("txCodewordValid", {15'h0, txCodewordValid}, 16'h0000);
        wr(SPAB_ADDR_ANCTRL, 16'h0000);
        repeat (2) @(posedge clk);
        #1 chk("pcsMode", {14'h0, pcsMode}, 16'h0000);
        chk("txCodeword", txCodeword, (localAdvert & 16'h31e0) | 16'h4000);
        chk("txCodewordValid", {15'h0, txCodewordValid}, 16'h0001);
        // ability register keeps the last capture across restart and the mode change
        rd(SPAB_ADDR_ABILITY, ability);
        // loopback and power save in all four combinations
        foreach (ctrls[k]) begin
            c = ctrls[k];
            wr(SPAB_ADDR_DIGCTRL, c);
            rd(SPAB_ADDR_DIGCTRL, c);
            repeat (3) begin
                @(posedge clk);
                txDataIn <= 10'($random(seed));
                #1 pr = rxData;
                pi = txDataIn;
                @(posedge clk);
                #1 chk("txData", {6'h0, txData}, c[11] ? 16'h0 : {6'h0, c[14] ? pr : pi});
            end
            chk("rxEnable", {15'h0, rxEnable}, {15'h0, !c[11]});
            chk("txEnable", {15'h0, txEnable}, {15'h0, !c[11]});
            chk("pllEnable", {15'h0, pllEnable}, 16'h0001);
        end
        close_out();
    end
endmodule // tb
